// ### bench/adc_output_port_control_bench.sv
// Self-checking bench for the converter output port control block
`timescale 1ns/1ps
module adc_output_port_control_bench;
	localparam int unsigned LAT = 3;
	logic        sys_clk, arst_n, sclk, fmt_n, oe_n, slew, run;
	logic        over, under, data_oe, oor, oor_oe, dvs, dvs_oe;
	logic        slew_lim, settled, cap_v, glitch;
	logic [11:0] conv, data;
	logic [12:0] cap, fcap;
	logic [13:0] q[$];
	int          n_fail = 0;
	int          checked = 0;
	int          seed = 1;
	// Port under test with a shortened pipeline
	aopc_output_port #(.LATENCY(LAT)) DUT (
		.sys_clk_i(sys_clk), .arst_n_i(arst_n), .sample_clk_i(sclk),
		.format_select_n_i(fmt_n), .output_enable_n_i(oe_n),
		.slew_limit_select_i(slew), .conv_data_i(conv),
		.conv_over_i(over), .conv_under_i(under), .data_o(data),
		.data_oe_o(data_oe), .out_of_range_o(oor),
		.out_of_range_oe_o(oor_oe), .data_valid_strobe_o(dvs),
		.data_valid_strobe_oe_o(dvs_oe), .slew_limit_o(slew_lim),
		.settled_o(settled));
	// Capture logic on the far side
	aopc_cap_model cap_model (
		.sys_clk_i(sys_clk), .run_i(run), .data_i(data),
		.data_oe_i(data_oe), .oor_i(oor), .oor_oe_i(oor_oe), .dvs_i(dvs),
		.dvs_oe_i(dvs_oe), .sclk_o(sclk), .cap_v_o(cap_v), .cap_o(cap),
		.fcap_o(fcap), .glitch_o(glitch));
	// 100 MHz system clock
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	// Count one comparison and report a mismatch
	task automatic check(input logic ok, input string what);
		checked++;
		if (ok !== 1'b1) begin
			n_fail++;
			$display("[ERR] %0t %s", $time, what);
		end
	endtask : check
	// Print counts and verdict, then stop
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : wrap_up
	// Driver: pins change at rises, core words at falls
	initial begin
		logic [31:0] r;
		{arst_n, fmt_n, oe_n, slew, run, over, under} = 7'h00;
		conv = 12'h000;
		repeat (8) @(posedge sys_clk);
		arst_n <= 1'b1;
		repeat (30) @(posedge sys_clk);
		check(settled === 1'b0, "settled without sample clock");
		run <= 1'b1;
		for (int i = 1; i <= 60; i++) begin
			@(posedge sclk);
			if (i == 8 || i == 9) check(settled === (i == 9), "warm-up");
			if (settled === 1'b1) q.push_back({over, under, conv});
			r = $random(seed);
			@(posedge sys_clk);
			fmt_n <= r[0];
			slew <= r[1];
			oe_n <= (i % 8) > 5;
			@(negedge sclk);
			@(posedge sys_clk);
			conv <= r[15:4];
			over <= r[16] & r[17];
			under <= r[18] & r[19] & ~(r[16] & r[17]);
		end
		repeat (40) @(posedge sys_clk);
		wrap_up();
	end
	// Watcher: a fall with a full pipeline releases the oldest note
	initial begin
		logic [13:0] e;
		logic [12:0] want, prev_cap;
		logic        en, f, prev_en;
		prev_en = 1'b0;
		forever begin
			@(negedge sclk);
			if (q.size() == LAT) begin
				e = q.pop_front();
				en = ~oe_n;
				f = fmt_n;
				want = {e[13] | e[12], e[11] ^ ~f, e[10:0]};
				check(slew_lim === slew, "slew level");
				// Release is looked at before the next rise may re-enable
				if (!en) begin
					check({data_oe, oor_oe, dvs_oe} === 3'b000, "driven");
				end
				for (int k = 0; k < 14 && cap_v !== 1'b1; k++) begin
					@(negedge sys_clk);
				end
				if (en) begin
					check(cap_v === 1'b1, "no strobe rise");
					check(cap === want, "word");
					if (prev_en) begin
						check(fcap === prev_cap, "fall capture");
					end
					prev_cap = cap;
				end
				prev_en = en;
			end
		end
	end
	// Data must not move while the strobe is high
	always @(negedge sys_clk) begin
		if (glitch === 1'b1) check(1'b0, "data moved in strobe high");
	end
	// Watchdog against a hang
	initial begin
		#50000;
		n_fail++;
		wrap_up();
	end
endmodule : adc_output_port_control_bench

// ### bench/aopc_cap_model.sv
// Capture-side partner: sample clock source and word capture
`timescale 1ns/1ps
module aopc_cap_model (
	// Clock and run control
	input  wire logic        sys_clk_i,
	input  wire logic        run_i,
	// Port pins and their enables
	input  wire logic [11:0] data_i,
	input  wire logic        data_oe_i,
	input  wire logic        oor_i,
	input  wire logic        oor_oe_i,
	input  wire logic        dvs_i,
	input  wire logic        dvs_oe_i,
	// Sample clock and capture results
	output logic             sclk_o,
	output logic             cap_v_o,
	output logic [12:0]      cap_o,
	output logic [12:0]      fcap_o,
	output logic             glitch_o
);
	logic [12:0] last_r = 13'h0000;
	logic        dvs_last_r = 1'b0;
	logic        dvs_prev_r;
	logic        oe_prev_r;
	logic        sclk_d_r = 1'b0;
	logic [12:0] wire_w;
	logic        dvs_w;
	// Sample clock, 160 ns, held low while run is off
	initial begin
		sclk_o = 1'b0;
		#3.7;
		forever #80 sclk_o = run_i & ~sclk_o;
	end
	// Released lines float to the inverse of the last driven level
	assign wire_w = {oor_oe_i ? oor_i : ~last_r[12],
		data_oe_i ? data_i : ~last_r[11:0]};
	assign dvs_w = dvs_oe_i ? dvs_i : ~dvs_last_r;
	// Remember driven levels, the previous strobe and the sample clock
	always @(posedge sys_clk_i) begin
		if (data_oe_i) last_r[11:0] <= data_i;
		if (oor_oe_i) last_r[12] <= oor_i;
		if (dvs_oe_i) dvs_last_r <= dvs_i;
		dvs_prev_r <= dvs_w;
		oe_prev_r <= data_oe_i;
		sclk_d_r <= sclk_o;
	end
	// Heavy-load capture: take the standing word at the sample clock fall
	always @(posedge sys_clk_i) begin
		if (sclk_d_r & ~sclk_o) fcap_o <= wire_w;
	end
	// Capture on the strobe rise, only while the port is selected
	always @(posedge sys_clk_i) begin
		cap_v_o <= dvs_oe_i & dvs_w & ~dvs_prev_r;
		cap_o <= wire_w;
		glitch_o <= oe_prev_r & data_oe_i & dvs_i & (data_i != last_r[11:0]);
	end
endmodule : aopc_cap_model

// ### hw/aopc_fifo.sv
// Small synchronous FIFO holding conversion words in flight
`timescale 1ns/1ps
module aopc_fifo #(
	parameter int unsigned WIDTH = aopc_pkg::WORD_W,
	parameter int unsigned DEPTH = aopc_pkg::FIFO_DEPTH
) (
	// Clock and reset
	input  wire logic      sys_clk_i,
	input  wire logic      arst_n_i,
	// Both handshake sides
	aopc_fifo_if.fifo      f
);
	localparam int unsigned AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW-1:0]    wptr_r;
	logic [AW-1:0]    rptr_r;
	logic [AW:0]      cnt_r;
	logic             do_push;
	logic             do_pop;

	// Honest full and empty from the word count
	assign f.push_ready = (cnt_r != (AW+1)'(DEPTH));
	assign f.pop_valid  = (cnt_r != '0);
	assign f.pop_data   = mem_r[rptr_r];
	assign f.level      = aopc_pkg::LVL_W'(cnt_r);
	assign do_push      = f.push_valid & f.push_ready;
	assign do_pop       = f.pop_ready & f.pop_valid;

	// Storage array, written only on an accepted push
	always_ff @(posedge sys_clk_i) begin
		if (do_push) begin
			mem_r[wptr_r] <= f.push_data;
		end
	end

	// Pointers and fill count
	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			wptr_r <= '0;
			rptr_r <= '0;
			cnt_r  <= '0;
		end else begin
			if (do_push) begin
				wptr_r <= wptr_r + 1'b1;
			end
			if (do_pop) begin
				rptr_r <= rptr_r + 1'b1;
			end
			unique case ({do_push, do_pop})
				2'b10: cnt_r <= cnt_r + 1'b1;
				2'b01: cnt_r <= cnt_r - 1'b1;
				default: cnt_r <= cnt_r;
			endcase
		end
	end

	// Count never passes the depth
	fifo_bound_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
		cnt_r <= (AW+1)'(DEPTH))
		else $error("fifo count above depth");
endmodule : aopc_fifo

// ### hw/aopc_fifo_if.sv
// Handshake bundle between the output port control and its sample FIFO
`timescale 1ns/1ps
interface aopc_fifo_if;
	logic                           push_valid;
	logic                           push_ready;
	logic [aopc_pkg::WORD_W-1:0]    push_data;
	logic                           pop_valid;
	logic                           pop_ready;
	logic [aopc_pkg::WORD_W-1:0]    pop_data;
	logic [aopc_pkg::LVL_W-1:0]     level;

	modport fifo (
		input  push_valid, push_data, pop_ready,
		output push_ready, pop_valid, pop_data, level
	);
	modport user (
		output push_valid, push_data, pop_ready,
		input  push_ready, pop_valid, pop_data, level
	);
endinterface : aopc_fifo_if

// ### hw/aopc_output_port.sv
// Output stage of the sampling converter: coding, flags, strobe, enables
// What this block does
// - Format select low: invert the top data bit for two's complement.
// - Format select high: pass straight binary, top bit unchanged.
// - Output enable high: all data drivers released, sampling goes on.
// - Output enable low again: drive current data after a short delay.
// - Out-of-range flag low in range, high above maximum or below minimum.
// - Data-valid strobe is an image of the sample clock, aligned to data.
// - Strobe and out-of-range flag are released with the data bits.
// - All data outputs change in step with the sample clock falling edge.
// - Slew select high limits drive; low gives the faster edges.
// - Each result appears a fixed number of sample cycles after sampling.
// - After power-on, outputs are unreliable for several sample cycles.
`timescale 1ns/1ps
module aopc_output_port #(
	parameter int unsigned LATENCY = aopc_pkg::LATENCY_DEF
) (
	// Clock and reset
	input  wire logic                        sys_clk_i,
	input  wire logic                        arst_n_i,
	// Pins from outside, asynchronous
	input  wire logic                        sample_clk_i,
	input  wire logic                        format_select_n_i,
	input  wire logic                        output_enable_n_i,
	input  wire logic                        slew_limit_select_i,
	// Conversion core results, same clock
	input  wire logic [aopc_pkg::DATA_W-1:0] conv_data_i,
	input  wire logic                        conv_over_i,
	input  wire logic                        conv_under_i,
	// Output pins with enables
	output logic [aopc_pkg::DATA_W-1:0]      data_o,
	output logic                             data_oe_o,
	output logic                             out_of_range_o,
	output logic                             out_of_range_oe_o,
	output logic                             data_valid_strobe_o,
	output logic                             data_valid_strobe_oe_o,
	// Drive and status
	output logic                             slew_limit_o,
	output logic                             settled_o
);
	logic [aopc_pkg::SYNC_W-1:0] sync1_r;
	logic [aopc_pkg::SYNC_W-1:0] sync2_r;
	logic                        sclk_prev_r;
	logic                        sclk_rise;
	logic                        sclk_fall;
	logic                        fmt_n;
	logic                        oen_n;
	logic [aopc_pkg::WARM_W-1:0] warm_cnt_r;
	logic                        settled;
	logic                        pop_fire;
	logic [aopc_pkg::DATA_W-1:0] raw_word;
	logic                        oe_r;

	aopc_fifo_if fif ();

	aopc_fifo #(
		.WIDTH (aopc_pkg::WORD_W),
		.DEPTH (aopc_pkg::FIFO_DEPTH)
	) u_fifo (
		.sys_clk_i (sys_clk_i),
		.arst_n_i  (arst_n_i),
		.f         (fif.fifo)
	);

	// Two-stage synchronisers for every pin input
	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			sync1_r <= aopc_pkg::SYNC_RST;
			sync2_r <= aopc_pkg::SYNC_RST;
		end else begin
			sync1_r <= {slew_limit_select_i, output_enable_n_i,
				format_select_n_i, sample_clk_i};
			sync2_r <= sync1_r;
		end
	end

	// Sample clock edge finder on the synchronised level
	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			sclk_prev_r <= 1'b0;
		end else begin
			sclk_prev_r <= sync2_r[aopc_pkg::PIN_SCLK];
		end
	end

	assign sclk_rise = sync2_r[aopc_pkg::PIN_SCLK] & ~sclk_prev_r;
	assign sclk_fall = ~sync2_r[aopc_pkg::PIN_SCLK] & sclk_prev_r;
	assign fmt_n     = sync2_r[aopc_pkg::PIN_FMT];
	assign oen_n     = sync2_r[aopc_pkg::PIN_OEN];

	// Warm-up count of sample clocks; no clock means no start-up
	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			warm_cnt_r <= '0;
		end else if (sclk_rise && !settled) begin
			warm_cnt_r <= warm_cnt_r + 1'b1;
		end
	end

	assign settled   = (warm_cnt_r == aopc_pkg::WARM_W'(aopc_pkg::WARMUP_SCLK));
	assign settled_o = settled;

	// Push one sample word per rising edge once warmed up
	assign fif.push_valid = sclk_rise & settled;
	assign fif.push_data  = {conv_over_i, conv_under_i, conv_data_i};

	// Pop on a falling edge only when the pipeline holds LATENCY words
	assign fif.pop_ready = sclk_fall &
		(fif.level == aopc_pkg::LVL_W'(LATENCY));
	assign pop_fire      = fif.pop_ready & fif.pop_valid;
	assign raw_word      = fif.pop_data[aopc_pkg::DATA_W-1:0];

	// Data word and range flag, updated only at the falling edge
	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			data_o         <= aopc_pkg::DATA_RST;
			out_of_range_o <= 1'b0;
		end else if (pop_fire) begin
			if (fmt_n) begin
				data_o <= raw_word;
			end else begin
				data_o <= {~raw_word[aopc_pkg::TOP_BIT],
					raw_word[aopc_pkg::TOP_BIT-1:0]};
			end
			out_of_range_o <= fif.pop_data[aopc_pkg::OVER_BIT] |
				fif.pop_data[aopc_pkg::UNDER_BIT];
		end
	end

	// Strobe follows the sample clock, same edge as the data update
	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			data_valid_strobe_o <= 1'b0;
		end else begin
			data_valid_strobe_o <= sync2_r[aopc_pkg::PIN_SCLK];
		end
	end

	// One enable for all pins; pipeline keeps running while released
	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			oe_r <= 1'b0;
		end else begin
			oe_r <= ~oen_n;
		end
	end

	assign data_oe_o              = oe_r;
	assign out_of_range_oe_o      = oe_r;
	assign data_valid_strobe_oe_o = oe_r;

	// Edge rate control for the pad drivers
	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			slew_limit_o <= 1'b0;
		end else begin
			slew_limit_o <= sync2_r[aopc_pkg::PIN_SLEW];
		end
	end

	// Rule checks on the popped words, the strobe and the enables
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!arst_n_i);

	fmt_invert_a: assert property (pop_fire && !fmt_n |=>
		data_o[11] == !$past(fif.pop_data[11]))
		else $error("top bit not inverted in two's complement");
	fmt_pass_a: assert property (pop_fire && fmt_n |=>
		data_o == $past(fif.pop_data[11:0]))
		else $error("straight binary word altered");
	oe_release_a: assert property (oen_n |=> !data_oe_o)
		else $error("data driven while enable is high");
	oe_resume_a: assert property ($fell(oen_n) |=> data_oe_o)
		else $error("data not driven one cycle after enable");
	range_flag_a: assert property (pop_fire |=>
		out_of_range_o == ($past(fif.pop_data[13]) || $past(fif.pop_data[12])))
		else $error("range flag mismatch");
	strobe_image_a: assert property ($rose(sync2_r[0]) |=>
		data_valid_strobe_o ##1 data_valid_strobe_o || $fell(sync2_r[0]))
		else $error("strobe does not follow sample clock");
	oe_group_a: assert property (oen_n |=>
		!out_of_range_oe_o && !data_valid_strobe_oe_o)
		else $error("flag or strobe driven while enable is high");
	fall_step_a: assert property ($changed(data_o) |->
		$past(sclk_fall) && !data_valid_strobe_o)
		else $error("data changed off the falling edge");
	slew_sel_a: assert property ($rose(sync2_r[3]) |=> slew_limit_o)
		else $error("slew limit not applied");
	fixed_lat_a: assert property (sclk_rise && settled |=>
		fif.level <= aopc_pkg::LVL_W'(LATENCY))
		else $error("pipeline deeper than the latency");
	warm_hold_a: assert property (!settled_o |-> !fif.push_valid)
		else $error("sample taken during warm-up");
	strobe_rise_a: assert property (sclk_rise |=>
		data_valid_strobe_o)
		else $error("strobe did not rise with the sample clock");
	strobe_fall_a: assert property (pop_fire |=>
		$fell(data_valid_strobe_o))
		else $error("word not launched with the strobe fall");
	slew_fast_a: assert property ($fell(sync2_r[aopc_pkg::PIN_SLEW]) |=>
		!slew_limit_o)
		else $error("slew limit kept after select went low");
	push_taken_a: assert property (sclk_rise && settled |->
		fif.push_valid && fif.push_ready)
		else $error("sample dropped by the pipeline");
	warm_keep_a: assert property (settled_o |=>
		settled_o)
		else $error("warm-up state lost");
	oe_driven_a: assert property (!oen_n |=>
		data_oe_o)
		else $error("data released while enable is low");

	// Main scenarios worth seeing at least once
	two_comp_c: cover property (pop_fire && !fmt_n);
	over_range_c: cover property (pop_fire && fif.pop_data[13]);
	oe_cycle_c: cover property ($fell(data_oe_o) ##[1:40] $rose(data_oe_o));
	settle_c: cover property ($rose(settled_o));
endmodule : aopc_output_port

// ### hw/aopc_pkg.sv
// Constants shared by the converter output port control block
package aopc_pkg;
	localparam int unsigned DATA_W      = 12;
	localparam int unsigned TOP_BIT     = 11;
	localparam int unsigned WORD_W      = 14;
	localparam int unsigned OVER_BIT    = 13;
	localparam int unsigned UNDER_BIT   = 12;
	localparam int unsigned FIFO_DEPTH  = 8;
	localparam int unsigned LVL_W       = 4;
	localparam int unsigned LATENCY_DEF = 4;
	localparam int unsigned WARMUP_SCLK = 8;
	localparam int unsigned WARM_W      = 4;
	localparam int unsigned SYNC_W      = 4;
	localparam int unsigned PIN_SCLK    = 0;
	localparam int unsigned PIN_FMT     = 1;
	localparam int unsigned PIN_OEN     = 2;
	localparam int unsigned PIN_SLEW    = 3;
	localparam logic [11:0] DATA_RST    = 12'h000;
	localparam logic [3:0]  SYNC_RST    = 4'h4;
endpackage : aopc_pkg
